// [src/dss_pkg.sv]
// Shared constants and state types of the safe stop and speed guard block.
package dss_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int SPD_W = 16;
    localparam int TMR_W = 32;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 4000;
    // Interval after which the braking speed must not have risen.
    localparam int DECR_CHK_NS   = 1000;
    localparam int DECR_CHK_CYC  =
        (DECR_CHK_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // ------------------------------------------------------------------
    // States
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        STOP_IDLE  = 2'h0,
        STOP_BRAKE = 2'h1,
        STOP_OFF   = 2'h3,
        STOP_FAULT = 2'h2
    } dss_stop_t;

    typedef enum logic [1:0] {
        GRD_OFF  = 2'h0,
        GRD_RAMP = 2'h1,
        GRD_MON  = 2'h3,
        GRD_TRIP = 2'h2
    } dss_guard_t;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam dss_stop_t  STOP_RST = STOP_IDLE;
    localparam dss_guard_t GRD_RST  = GRD_OFF;
    localparam logic [TMR_W-1:0] TMR_RST = 32'h0000_0000;
    localparam logic [SPD_W-1:0] SPD_RST = 16'h0000;

endpackage

// [src/dss_speed_cmp.sv]
// Magnitude of a signed speed compared against an unsigned limit.
`timescale 1ns/1ps
module dss_speed_cmp #(
    parameter int W = dss_pkg::SPD_W
) (
    input  wire logic signed [W-1:0] speed,
    input  wire logic        [W-1:0] limit,
    output logic             [W-1:0] abs_val,
    output logic                     above,
    output logic                     below
);

    // The most negative speed still maps to its true magnitude because
    // the result is read as unsigned.
    assign abs_val = speed[W-1] ? W'(-speed) : W'(speed);
    assign above   = abs_val > limit;
    assign below   = abs_val < limit;

endmodule

// [src/dss_supervisor.sv]
// Controlled stop with torque removal and limited speed guard supervisor.
//
// What this block does
// RL1 - Stop offers timer and speed-monitored variants.
// RL2 - Stop request comes from input or fieldbus.
// RL3 - Timer variant starts delay timer at selection.
// RL4 - Selected stop commands the quick-stop ramp.
// RL5 - Stop active status shown while braking, until torque off.
// RL6 - Timer expiry triggers torque off.
// RL7 - Torque off active reported on both paths.
// RL8 - Monitored variant checks speed does not rise.
// RL9 - Monitored variant cuts torque below low threshold.
// RL10 - Guard request comes from input or fieldbus.
// RL11 - Guard clamps setpoint below the limit.
// RL12 - Guard brakes on ramp while above limit.
// RL13 - Guard compares absolute speed with limit.
// RL14 - Guard active status shown while monitoring.
// RL15 - Guard overspeed enters safe stop, brakes hard.
// RL16 - Torque off delivers zero torque, motor coasts.
// RL17 - Delay, threshold, limit held while function active.
// RL18 - Speed rising over a check interval means fault, torque off.
`timescale 1ns/1ps
module dss_supervisor #(
    parameter int SPD_W   = dss_pkg::SPD_W,
    parameter int TMR_W   = dss_pkg::TMR_W,
    parameter int CHK_CYC = dss_pkg::DECR_CHK_CYC
) (
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire logic              stop_sel_fsi,
    input  wire logic              stop_sel_bus,
    input  wire logic              guard_sel_fsi,
    input  wire logic              guard_sel_bus,
    input  wire logic              variant_ext,
    input  wire logic [TMR_W-1:0]  cfg_delay,
    input  wire logic [SPD_W-1:0]  cfg_low_speed,
    input  wire logic [SPD_W-1:0]  cfg_speed_limit,
    input  wire logic              fault_ack,
    input  wire logic signed [SPD_W-1:0] speed_act,
    input  wire logic signed [SPD_W-1:0] speed_set_in,
    output logic signed [SPD_W-1:0] speed_set_out,
    output logic                   quick_stop_ramp,
    output logic                   torque_off,
    output logic                   stop_active,
    output logic                   torque_off_fso,
    output logic                   torque_off_bus,
    output logic                   guard_active_fso,
    output logic                   guard_active_bus,
    output logic                   safe_stop_fault
);

    // ------------------------------------------------------------------
    // Requests and speed comparison
    // ------------------------------------------------------------------
    dss_pkg::dss_stop_t  stop_q;
    dss_pkg::dss_guard_t grd_q;
    logic [TMR_W-1:0]    delay_q;
    logic [TMR_W-1:0]    tmr_q;
    logic [SPD_W-1:0]    low_q;
    logic [SPD_W-1:0]    limit_q;
    logic [SPD_W-1:0]    ref_q;
    logic [15:0]         chk_q;
    logic                ext_q, trip_q, to_rep_q;
    logic                stop_req, guard_req;
    logic [SPD_W-1:0]    spd_abs;
    logic                spd_above, spd_low;
    logic [SPD_W-1:0]    set_abs;
    logic                set_over, tmr_done, chk_tick;
    logic                stall, guard_trip, release_ok;

    assign stop_req  = stop_sel_fsi | stop_sel_bus;   // RL2
    assign guard_req = guard_sel_fsi | guard_sel_bus; // RL10

    dss_speed_cmp #(
        .W (SPD_W)
    ) u_cmp_guard (
        .speed   (speed_act),
        .limit   (limit_q),
        .abs_val (spd_abs),
        .above   (spd_above),
        .below   ()
    );

    dss_speed_cmp #(
        .W (SPD_W)
    ) u_cmp_low (
        .speed   (speed_act),
        .limit   (low_q),
        .abs_val (),
        .above   (),
        .below   (spd_low)
    );

    dss_speed_cmp #(
        .W (SPD_W)
    ) u_cmp_set (
        .speed   (speed_set_in),
        .limit   (limit_q),
        .abs_val (set_abs),
        .above   (),
        .below   ()
    );

    assign set_over   = set_abs >= limit_q;
    assign tmr_done   = tmr_q >= delay_q;
    assign chk_tick   = chk_q == 16'(CHK_CYC - 1);
    assign stall      = chk_tick && (spd_abs > ref_q);             // RL8
    assign guard_trip = (grd_q == dss_pkg::GRD_MON) && spd_above;  // RL15
    assign release_ok = !stop_req && !trip_q;

    // ------------------------------------------------------------------
    // Configuration capture
    // ------------------------------------------------------------------
    // Settings are taken only while the function is idle, so a change
    // during a running sequence cannot shorten or weaken it.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            delay_q <= dss_pkg::TMR_RST;
            low_q   <= dss_pkg::SPD_RST;
            ext_q   <= 1'b0;
        end else if (stop_q == dss_pkg::STOP_IDLE) begin
            delay_q <= cfg_delay;         // RL17
            low_q   <= cfg_low_speed;     // RL17
            ext_q   <= variant_ext | guard_trip; // RL1
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            limit_q <= dss_pkg::SPD_RST;
        end else if (grd_q == dss_pkg::GRD_OFF) begin
            limit_q <= cfg_speed_limit;   // RL17
        end
    end

    // ------------------------------------------------------------------
    // Delay timer and deceleration check
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tmr_q <= dss_pkg::TMR_RST;
        end else if (stop_q == dss_pkg::STOP_BRAKE && !ext_q) begin
            if (!tmr_done) begin
                tmr_q <= tmr_q + TMR_W'(1); // RL3
            end
        end else begin
            tmr_q <= dss_pkg::TMR_RST;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            chk_q <= 16'h0000;
            ref_q <= dss_pkg::SPD_RST;
        end else if (stop_q == dss_pkg::STOP_BRAKE && ext_q) begin
            chk_q <= chk_tick ? 16'h0000 : chk_q + 16'h0001;
            if (chk_tick) begin
                ref_q <= spd_abs;         // RL8
            end
        end else begin
            chk_q <= 16'h0000;
            ref_q <= spd_abs;
        end
    end

    // ------------------------------------------------------------------
    // Stop sequence
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stop_q <= dss_pkg::STOP_RST;
        end else begin
            unique case (stop_q)
                dss_pkg::STOP_IDLE: begin
                    if (stop_req || guard_trip) begin
                        stop_q <= dss_pkg::STOP_BRAKE; // RL4
                    end
                end
                dss_pkg::STOP_BRAKE: begin
                    if (release_ok) begin
                        stop_q <= dss_pkg::STOP_IDLE;
                    end else if (ext_q && stall) begin
                        stop_q <= dss_pkg::STOP_FAULT; // RL18
                    end else if (ext_q && spd_low) begin
                        stop_q <= dss_pkg::STOP_OFF;   // RL9
                    end else if (!ext_q && tmr_done) begin
                        stop_q <= dss_pkg::STOP_OFF;   // RL6
                    end
                end
                dss_pkg::STOP_OFF: begin
                    if (release_ok) begin
                        stop_q <= dss_pkg::STOP_IDLE;
                    end
                end
                dss_pkg::STOP_FAULT: begin
                    if (fault_ack && release_ok) begin
                        stop_q <= dss_pkg::STOP_IDLE;
                    end
                end
            endcase
        end
    end

    // A new trip in the acknowledge cycle keeps the flag set.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            trip_q <= 1'b0;
        end else if (guard_trip) begin
            trip_q <= 1'b1;               // RL15
        end else if (fault_ack && !guard_req) begin
            trip_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Limited speed guard
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            grd_q <= dss_pkg::GRD_RST;
        end else begin
            unique case (grd_q)
                dss_pkg::GRD_OFF: begin
                    if (guard_req) begin
                        grd_q <= dss_pkg::GRD_RAMP;
                    end
                end
                dss_pkg::GRD_RAMP: begin
                    if (!guard_req) begin
                        grd_q <= dss_pkg::GRD_OFF;
                    end else if (!spd_above) begin
                        grd_q <= dss_pkg::GRD_MON; // RL12
                    end
                end
                dss_pkg::GRD_MON: begin
                    if (guard_trip) begin
                        grd_q <= dss_pkg::GRD_TRIP; // RL13
                    end else if (!guard_req) begin
                        grd_q <= dss_pkg::GRD_OFF;
                    end
                end
                dss_pkg::GRD_TRIP: begin
                    if (!trip_q) begin
                        grd_q <= dss_pkg::GRD_OFF;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign torque_off = stop_q == dss_pkg::STOP_OFF ||
                        stop_q == dss_pkg::STOP_FAULT;
    assign stop_active = stop_q == dss_pkg::STOP_BRAKE; // RL5
    // Ramp is dropped once torque is off: the motor then only coasts.
    assign quick_stop_ramp = !torque_off &&
        (stop_active || grd_q == dss_pkg::GRD_RAMP);    // RL4
    assign guard_active_fso = grd_q == dss_pkg::GRD_MON; // RL14
    assign guard_active_bus = grd_q == dss_pkg::GRD_MON; // RL14
    assign safe_stop_fault  = trip_q || stop_q == dss_pkg::STOP_FAULT;
    assign torque_off_fso   = to_rep_q;
    assign torque_off_bus   = to_rep_q;

    // Reported one cycle after the power stage has been cut.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            to_rep_q <= 1'b0;
        end else begin
            to_rep_q <= torque_off;       // RL7
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            speed_set_out <= SPD_W'(0);
        end else if (torque_off || stop_active) begin
            speed_set_out <= SPD_W'(0);   // RL16
        end else if (grd_q != dss_pkg::GRD_OFF && set_over) begin
            // A zero limit clamps to zero instead of wrapping round.
            speed_set_out <= speed_set_in[SPD_W-1]
                ? SPD_W'(-(limit_q - SPD_W'(|limit_q)))
                : SPD_W'(limit_q - SPD_W'(|limit_q)); // RL11
        end else begin
            speed_set_out <= speed_set_in;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence s_basic_brake;
        stop_q == dss_pkg::STOP_BRAKE && !ext_q && stop_req;
    endsequence

    chk_timer_starts: assert property (@(posedge clk) disable iff (!rstn)
        $rose(stop_active) |-> tmr_q == dss_pkg::TMR_RST) // RL3
        else $error("Delay timer not cleared at stop start.");

    chk_timer_off: assert property (@(posedge clk) disable iff (!rstn)
        s_basic_brake ##0 tmr_done |=> torque_off) // RL6
        else $error("Torque not removed at timer expiry.");

    chk_stop_ramp: assert property (@(posedge clk) disable iff (!rstn)
        stop_active |-> quick_stop_ramp && speed_set_out == 0 ||
        $rose(stop_active)) // RL4
        else $error("Stop active without quick-stop ramp.");

    chk_report_off: assert property (@(posedge clk) disable iff (!rstn)
        torque_off |=> torque_off_fso && torque_off_bus) // RL7
        else $error("Torque off not reported one cycle later.");

    chk_low_speed: assert property (@(posedge clk) disable iff (!rstn)
        stop_q == dss_pkg::STOP_BRAKE && ext_q && !release_ok && !stall
        && spd_low |=> stop_q == dss_pkg::STOP_OFF) // RL9
        else $error("Low speed did not remove torque.");

    chk_stall_fault: assert property (@(posedge clk) disable iff (!rstn)
        stop_q == dss_pkg::STOP_BRAKE && ext_q && !release_ok && stall
        |=> safe_stop_fault && torque_off) // RL18
        else $error("Speed rise while braking not faulted.");

    chk_guard_trip: assert property (@(posedge clk) disable iff (!rstn)
        grd_q == dss_pkg::GRD_MON && spd_above |=> trip_q ##1
        (stop_q != dss_pkg::STOP_IDLE)) // RL15
        else $error("Overspeed under guard not acted on.");

    chk_clamp_limit: assert property (@(posedge clk) disable iff (!rstn)
        grd_q == dss_pkg::GRD_MON && !torque_off && !stop_active
        && limit_q != 0 && $stable(limit_q)
        |=> !$past(set_over) || (speed_set_out < $signed(limit_q)
        && speed_set_out > -$signed(limit_q))) // RL11
        else $error("Setpoint not clamped below the limit.");

    chk_guard_flag: assert property (@(posedge clk) disable iff (!rstn)
        guard_active_fso |-> guard_req || $past(guard_req)) // RL14
        else $error("Guard active shown without request.");

endmodule

// [dv/dss_ctrl_model.sv]
// Far-side model: safety controller request lines and a simple motor.
`timescale 1ns/1ps
module dss_ctrl_model #(
    parameter int W    = dss_pkg::SPD_W,
    parameter int STEP = 4
) (
    input  wire logic                clk,
    input  wire logic                rstn,
    input  wire logic                stop_req,
    input  wire logic                guard_req,
    input  wire logic                use_bus,
    input  wire logic                stall,
    input  wire logic                spd_load,
    input  wire logic signed [W-1:0] spd_init,
    input  wire logic                quick_stop_ramp,
    input  wire logic                torque_off,
    output logic                     stop_sel_fsi,
    output logic                     stop_sel_bus,
    output logic                     guard_sel_fsi,
    output logic                     guard_sel_bus,
    output logic signed [W-1:0]      speed_act
);
    function automatic logic signed [W-1:0] toward(
        logic signed [W-1:0] s, int st);
        if (s <= st && s >= -st) begin
            return '0;
        end
        return (s > 0) ? W'(s - st) : W'(s + st);
    endfunction

    // Each request travels on exactly one of its two paths.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stop_sel_fsi  <= 1'b0;
            stop_sel_bus  <= 1'b0;
            guard_sel_fsi <= 1'b0;
            guard_sel_bus <= 1'b0;
        end else begin
            stop_sel_fsi  <= stop_req && !use_bus;
            stop_sel_bus  <= stop_req && use_bus;
            guard_sel_fsi <= guard_req && !use_bus;
            guard_sel_bus <= guard_req && use_bus;
        end
    end

    // A stalled drive with a positive speed speeds up under braking so the fault path is hit.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            speed_act <= '0;
        end else if (spd_load) begin
            speed_act <= spd_init;
        end else if (torque_off) begin
            speed_act <= toward(speed_act, 1);
        end else if (quick_stop_ramp && stall) begin
            speed_act <= speed_act + 1'b1;
        end else if (quick_stop_ramp) begin
            speed_act <= toward(speed_act, STEP);
        end
    end
endmodule

// [dv/dss_supervisor_tb_top.sv]
// Self-checking bench of the safe stop and speed guard supervisor.
`timescale 1ns/1ps
module dss_supervisor_tb_top;
    localparam int W   = dss_pkg::SPD_W;
    localparam int CHK = 8;
    logic clk, rstn, stop_req, guard_req, use_bus, stall, spd_load;
    logic variant_ext, fault_ack;
    logic signed [W-1:0] spd_init, speed_set_in, speed_act, speed_set_out;
    logic [dss_pkg::TMR_W-1:0] cfg_delay;
    logic [W-1:0] cfg_low_speed, cfg_speed_limit;
    logic stop_sel_fsi, stop_sel_bus, guard_sel_fsi, guard_sel_bus;
    logic quick_stop_ramp, torque_off, stop_active, safe_stop_fault;
    logic torque_off_fso, torque_off_bus, guard_active_fso, guard_active_bus;
    int error_cnt, cmp_count, cyc, t0, d, v;
    int exp_q[$];
    logic to_d, sa_d;

    dss_supervisor #(.CHK_CYC(CHK)) dss_supervisor_inst (
        .clk(clk), .rstn(rstn), .stop_sel_fsi(stop_sel_fsi),
        .stop_sel_bus(stop_sel_bus), .guard_sel_fsi(guard_sel_fsi),
        .guard_sel_bus(guard_sel_bus), .variant_ext(variant_ext),
        .cfg_delay(cfg_delay), .cfg_low_speed(cfg_low_speed),
        .cfg_speed_limit(cfg_speed_limit), .fault_ack(fault_ack),
        .speed_act(speed_act), .speed_set_in(speed_set_in),
        .speed_set_out(speed_set_out), .quick_stop_ramp(quick_stop_ramp),
        .torque_off(torque_off), .stop_active(stop_active),
        .torque_off_fso(torque_off_fso), .torque_off_bus(torque_off_bus),
        .guard_active_fso(guard_active_fso),
        .guard_active_bus(guard_active_bus),
        .safe_stop_fault(safe_stop_fault));

    dss_ctrl_model dss_ctrl_model_inst (
        .clk(clk), .rstn(rstn), .stop_req(stop_req), .guard_req(guard_req),
        .use_bus(use_bus), .stall(stall), .spd_load(spd_load),
        .spd_init(spd_init), .quick_stop_ramp(quick_stop_ramp),
        .torque_off(torque_off), .stop_sel_fsi(stop_sel_fsi),
        .stop_sel_bus(stop_sel_bus), .guard_sel_fsi(guard_sel_fsi),
        .guard_sel_bus(guard_sel_bus), .speed_act(speed_act));

    // --------------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------------
    task automatic check(string nm, logic [31:0] e, logic [31:0] g);
        cmp_count++;
        if (e !== g) begin
            error_cnt++;
            $display("ERROR %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    task automatic complete_run;
        $display("comparisons %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    function automatic logic signed [31:0] mag(logic signed [W-1:0] s);
        return (s < 0) ? -32'(s) : 32'(s);
    endfunction

    function automatic logic pick(int k);
        case (k)
            0: return stop_active;
            1: return torque_off;
            2: return guard_active_fso;
            3: return safe_stop_fault;
            default: return quick_stop_ramp;
        endcase
    endfunction

    // Bounded wait for a level; running out counts as a mismatch.
    task automatic wait_for(string nm, int k, int lim);
        int n;
        n = 0;
        @(negedge clk);
        while (pick(k) !== 1'b1 && n < lim) begin
            @(negedge clk);
            n++;
        end
        check(nm, 1, pick(k));
    endtask

    task automatic load(logic signed [W-1:0] s);
        @(posedge clk);
        spd_init <= s;
        spd_load <= 1'b1;
        @(posedge clk);
        spd_load <= 1'b0;
    endtask

    // The fault is acknowledged only once the request lines have dropped.
    task automatic clear;
        @(posedge clk);
        stop_req  <= 1'b0;
        guard_req <= 1'b0;
        stall     <= 1'b0;
        repeat (2) @(posedge clk);
        fault_ack <= 1'b1;
        @(posedge clk);
        fault_ack <= 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        check("safe_stop_fault", 0, safe_stop_fault);
        check("torque_off", 0, torque_off);
    endtask

    task automatic ext_stop(logic signed [W-1:0] s, logic stl);
        load(s);
        stall    <= stl;
        stop_req <= 1'b1;
        if (stl) begin
            wait_for("safe_stop_fault", 3, 2 * CHK + 6);
        end
        wait_for("torque_off", 1, 300);
        if (!stl) begin
            check("below low", 1, mag(speed_act) < 20);
            check("safe_stop_fault", 0, safe_stop_fault);
        end
        clear();
    endtask

    // --------------------------------------------------------------------
    // Result watcher: latency notes are taken off the queue in order
    // --------------------------------------------------------------------
    always @(negedge clk) begin
        if (!rstn) begin
            to_d = 1'b0;
            sa_d = 1'b0;
        end else begin
            cyc++;
            if (stop_active && !sa_d) begin
                t0 = cyc;
            end
            if (torque_off && !to_d) begin
                check("stop_active", 0, stop_active);
                if (exp_q.size() > 0) begin
                    check("latency", exp_q.pop_front(), cyc - t0);
                end
            end
            check("torque_off_fso", to_d, torque_off_fso);
            check("torque_off_bus", to_d, torque_off_bus);
            to_d = torque_off;
            sa_d = stop_active;
        end
    end

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        complete_run();
    end

    // --------------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------------
    initial begin
        {rstn, stop_req, guard_req, use_bus, stall, spd_load} = '0;
        {variant_ext, fault_ack} = '0;
        spd_init        = '0;
        speed_set_in    = '0;
        cfg_delay       = '0;
        cfg_low_speed   = 16'h0014;
        cfg_speed_limit = 16'h0064;
        void'($urandom(44));
        repeat (20) @(posedge clk);
        check("reset outputs", 0, {torque_off, stop_active, speed_set_out});
        rstn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            d = $urandom_range(0, 5);
            @(posedge clk);
            use_bus   <= 1'($urandom);
            cfg_delay <= d;
            exp_q.push_back(d + 1);
            stop_req  <= 1'b1;
            wait_for("stop_active", 0, 4);
            check("quick_stop_ramp", 1, quick_stop_ramp);
            @(posedge clk);
            cfg_delay <= 32'h0000_0040;
            wait_for("torque_off", 1, 80);
            clear();
        end
        @(posedge clk);
        variant_ext <= 1'b1;
        ext_stop(16'hFE70, 1'b0);
        ext_stop(16'h012C, 1'b1);
        @(posedge clk);
        variant_ext <= 1'b0;
        load(16'h012C);
        use_bus   <= 1'($urandom);
        guard_req <= 1'b1;
        wait_for("quick_stop_ramp", 4, 4);
        check("guard_active_fso", 0, guard_active_fso);
        wait_for("guard_active_fso", 2, 120);
        check("guard_active_bus", 1, guard_active_bus);
        check("guard within", 1, mag(speed_act) <= 100);
        check("quick_stop_ramp", 0, quick_stop_ramp);
        for (int k = 0; k < 8; k++) begin
            v = $urandom_range(0, 600) - 300;
            @(posedge clk);
            speed_set_in <= W'(v);
            repeat (3) @(posedge clk);
            @(negedge clk);
            d = (v >= 100) ? 99 : (v <= -100) ? -99 : v;
            check("speed_set_out", W'(d), speed_set_out);
        end
        load(16'hFF00);
        wait_for("safe_stop_fault", 3, 4);
        check("guard_active_fso", 0, guard_active_fso);
        wait_for("quick_stop_ramp", 4, 4);
        wait_for("torque_off", 1, 300);
        clear();
        complete_run();
    end
endmodule
